/* File: hdl/dacps_defs.vh */
`ifndef DACPS_DEFS_VH
`define DACPS_DEFS_VH

// sample word
`define DACPS_SAMPLE_W        8
`define DACPS_CODE_FULL       8'hff
`define DACPS_CODE_ZERO       8'h00

// sample fifo
`define DACPS_FIFO_DEPTH      16
`define DACPS_FIFO_AW         4
`define DACPS_FIFO_CW         5

// clock receiver modes
`define DACPS_MODE_W          2
`define DACPS_MODE_SINGLE     2'h0
`define DACPS_MODE_DIFF       2'h1
`define DACPS_MODE_PECL       2'h2

// timing, in ns, with the sys_clk period
`define DACPS_CLK_PERIOD_NS   8
`define DACPS_PD_MAX_NS       50
`define DACPS_WAKE_NS         5000
`define DACPS_PD_MAX_CYC      (`DACPS_PD_MAX_NS / `DACPS_CLK_PERIOD_NS)
`define DACPS_WAKE_CYC \
	((`DACPS_WAKE_NS + `DACPS_CLK_PERIOD_NS - 1) / `DACPS_CLK_PERIOD_NS)
`define DACPS_WAKE_W          10

// power states
`define DACPS_ST_W            2
`define DACPS_ST_RUN          2'h0
`define DACPS_ST_SLEEP        2'h1
`define DACPS_ST_WAKE         2'h2

`endif

/* File: hdl/dacps_sample_path.v */
// Summary of operation
// - take 8-bit straight binary samples, msb on bit 7, lsb on bit 0
// - all ones gives full scale on primary; complement carries remainder
// - capture each sample in an edge-triggered register on rising edge
// - capture and update path takes one word per sys_clk edge, 125 MSPS at the 8 ns period
// - strap picks single-ended, differential or terminated PECL receiver
// - power-down high switches output current off; low runs normally
// - power down within 50 ns; about 5 us before output valid again
`timescale 1ns/10ps
`include "dacps_defs.vh"

module dacps_fifo #(
	parameter WIDTH = `DACPS_SAMPLE_W,
	parameter DEPTH = `DACPS_FIFO_DEPTH
) (
	// clock and reset
	input  wire             sys_clk,
	input  wire             reset_n,
	// fill side
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	// drain side
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg  [WIDTH-1:0]           mem [0:DEPTH-1];
	reg  [`DACPS_FIFO_AW-1:0]  wr_ptr;
	reg  [`DACPS_FIFO_AW-1:0]  rd_ptr;
	reg  [`DACPS_FIFO_CW-1:0]  count;
	wire                       push;
	wire                       pop;

	assign in_ready  = (count != DEPTH[`DACPS_FIFO_CW-1:0]);
	assign out_valid = (count != {`DACPS_FIFO_CW{1'b0}});
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= {`DACPS_FIFO_AW{1'b0}};
			rd_ptr <= {`DACPS_FIFO_AW{1'b0}};
			count  <= {`DACPS_FIFO_CW{1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule // dacps_fifo

module dacps_sample_path (
	// clock and reset
	input  wire                       sys_clk,
	input  wire                       reset_n,
	// sample stream from upstream logic
	input  wire [`DACPS_SAMPLE_W-1:0] sample_data,
	input  wire                       sample_valid,
	output wire                       sample_ready,
	// straps and control
	input  wire                       clock_mode_strap_gnd,
	input  wire                       clock_mode_strap_vdd,
	input  wire                       power_down,
	// clock receiver setup
	output reg  [`DACPS_MODE_W-1:0]   clock_rx_mode,
	output reg                        clock_rx_pecl_term,
	// converter drive
	output reg  [`DACPS_SAMPLE_W-1:0] primary_current_output,
	output reg  [`DACPS_SAMPLE_W-1:0] complement_current_output,
	output reg                        output_current_on,
	output reg                        output_valid,
	output reg                        sample_update
);
	reg  [`DACPS_SAMPLE_W-1:0] code;
	reg  [`DACPS_SAMPLE_W-1:0] next_code;
	reg  [`DACPS_ST_W-1:0]     state;
	reg  [`DACPS_ST_W-1:0]     next_state;
	reg  [`DACPS_WAKE_W-1:0]   wake_cnt;
	reg                        strap_taken;
	wire [`DACPS_SAMPLE_W-1:0] fifo_data;
	wire                       fifo_valid;
	wire                       fifo_ready;
	wire                       take;

	// strap decode: tied low, tied high, or floating (neither)
	function [`DACPS_MODE_W-1:0] mode_of;
		input gnd;
		input vdd;
		begin
			if (gnd) begin
				mode_of = `DACPS_MODE_SINGLE;
			end else if (vdd) begin
				mode_of = `DACPS_MODE_DIFF;
			end else begin
				mode_of = `DACPS_MODE_PECL;
			end
		end
	endfunction

	// fifo absorbs bursts; sleeping stops the drain so it fills and stalls
	dacps_fifo #(
		.WIDTH (`DACPS_SAMPLE_W),
		.DEPTH (`DACPS_FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.in_data   (sample_data),
		.in_valid  (sample_valid),
		.in_ready  (sample_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready)
	);

	// one word per edge keeps the path at full clock rate
	assign fifo_ready = (state == `DACPS_ST_RUN) & ~power_down;
	assign take       = fifo_valid & fifo_ready;

	// strap is sampled once, on the first edge after reset release
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_taken        <= 1'b0;
			clock_rx_mode      <= `DACPS_MODE_SINGLE;
			clock_rx_pecl_term <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken        <= 1'b1;
			clock_rx_mode      <= mode_of(clock_mode_strap_gnd,
				clock_mode_strap_vdd);
			clock_rx_pecl_term <= (mode_of(clock_mode_strap_gnd,
				clock_mode_strap_vdd) == `DACPS_MODE_PECL);
		end
	end

	// power state: sleep at once, wake after the settle count
	always @* begin
		next_state = state;
		case (state)
			`DACPS_ST_RUN: begin
				if (power_down) begin
					next_state = `DACPS_ST_SLEEP;
				end
			end
			`DACPS_ST_SLEEP: begin
				if (!power_down) begin
					next_state = `DACPS_ST_WAKE;
				end
			end
			`DACPS_ST_WAKE: begin
				if (power_down) begin
					next_state = `DACPS_ST_SLEEP;
				end else if (wake_cnt ==
					`DACPS_WAKE_CYC - 1) begin
					next_state = `DACPS_ST_RUN;
				end
			end
			default: begin
				next_state = `DACPS_ST_RUN;
			end
		endcase
	end

	// a sample is latched only on a taken edge, otherwise held
	always @* begin
		next_code = code;
		if (take) begin
			next_code = fifo_data;
		end
	end

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state    <= `DACPS_ST_RUN;
			wake_cnt <= {`DACPS_WAKE_W{1'b0}};
			code     <= `DACPS_CODE_ZERO;
		end else begin
			state <= next_state;
			code  <= next_code;
			if (state == `DACPS_ST_WAKE && !power_down) begin
				wake_cnt <= wake_cnt + 1'b1;
			end else begin
				wake_cnt <= {`DACPS_WAKE_W{1'b0}};
			end
		end
	end

	// output stage: current cut in one edge, well inside the 50 ns limit
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			primary_current_output    <= `DACPS_CODE_ZERO;
			complement_current_output <= `DACPS_CODE_ZERO;
			output_current_on         <= 1'b0;
			output_valid              <= 1'b0;
			sample_update             <= 1'b0;
		end else begin
			sample_update <= take;
			output_valid  <= (next_state == `DACPS_ST_RUN) &
				~power_down;
			if (power_down || next_state != `DACPS_ST_RUN) begin
				output_current_on         <= 1'b0;
				primary_current_output    <= `DACPS_CODE_ZERO;
				complement_current_output <= `DACPS_CODE_ZERO;
			end else begin
				output_current_on         <= 1'b1;
				primary_current_output    <= next_code;
				complement_current_output <=
					`DACPS_CODE_FULL - next_code;
			end
		end
	end
endmodule // dacps_sample_path

/* File: tb/dacps_sample_path_monitor.sv */
`timescale 1ns/10ps
module dacps_sample_path_monitor (
	// clock, reset, inputs
	input wire       sys_clk,
	input wire       reset_n,
	input wire       power_down,
	input wire       clock_mode_strap_gnd,
	input wire       clock_mode_strap_vdd,
	// outputs
	input wire [1:0] clock_rx_mode,
	input wire       clock_rx_pecl_term,
	input wire [7:0] primary_current_output,
	input wire [7:0] complement_current_output,
	input wire       output_current_on,
	input wire       output_valid,
	input wire       sample_update
);
	// cycles since power-down was seen, saturating at 700
	reg [9:0] awake;
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			awake <= 10'h000;
		else if (power_down)
			awake <= 10'h001;
		else if (awake != 10'h000 && awake < 10'h2bc)
			awake <= awake + 10'h001;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	property p_cmpl;
		output_current_on |->
			complement_current_output == 8'hff - primary_current_output;
	endproperty
	a_cmpl: assert property (p_cmpl) else $error("bad complement");
	property p_pd;
		power_down |=> !output_current_on && primary_current_output == 8'h00;
	endproperty
	a_pd: assert property (p_pd) else $error("late power-down");
	property p_hold;
		!$stable(primary_current_output) && $past(output_current_on) &&
			output_current_on |-> sample_update;
	endproperty
	a_hold: assert property (p_hold) else $error("code moved");
	property p_upd;
		sample_update |-> output_current_on && output_valid;
	endproperty
	a_upd: assert property (p_upd) else $error("update while off");
	property p_strap;
		$past(reset_n) |-> clock_rx_mode == (clock_mode_strap_gnd ? 2'h0 :
			clock_mode_strap_vdd ? 2'h1 : 2'h2);
	endproperty
	a_strap: assert property (p_strap) else $error("bad mode");
	property p_term;
		clock_rx_pecl_term |-> clock_rx_mode == 2'h2;
	endproperty
	a_term: assert property (p_term) else $error("bad termination");
	// wake takes about 625 cycles, never much less
	property p_wake;
		output_valid |-> awake == 10'h000 || awake >= 10'h258;
	endproperty
	a_wake: assert property (p_wake) else $error("early wake");
	property p_woke;
		awake == 10'h2bc |-> output_valid;
	endproperty
	a_woke: assert property (p_woke) else $error("late wake");
endmodule // dacps_sample_path_monitor

bind dacps_sample_path dacps_sample_path_monitor u_mon (.sys_clk, .reset_n,
	.power_down, .clock_mode_strap_gnd, .clock_mode_strap_vdd,
	.clock_rx_mode, .clock_rx_pecl_term, .primary_current_output,
	.complement_current_output, .output_current_on, .output_valid,
	.sample_update);

/* File: tb/dacps_upstream_model.sv */
`timescale 1ns/10ps
module dacps_upstream_model (
	// clock, reset, start
	input wire       sys_clk,
	input wire       reset_n,
	input wire       go,
	// stream
	input wire       sample_ready,
	output reg [7:0] sample_data,
	output reg       sample_valid
);
	reg [4:0] left;
	// burst of 16 words, k * 17, spanning 00 to ff
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			left <= 5'h00;
			sample_valid <= 1'b0;
			sample_data <= 8'h00;
		end else if (go) begin
			left <= 5'h10;
			sample_valid <= 1'b1;
			sample_data <= 8'h00;
		end else if (sample_valid && sample_ready) begin
			left <= left - 5'h01;
			sample_valid <= left != 5'h01;
			// idle bus shows garbage, not a stale word
			sample_data <= left == 5'h01 ? ~sample_data : sample_data + 8'h11;
		end
	end
endmodule // dacps_upstream_model

/* File: tb/dacps_sample_path_tb_top.sv */
`timescale 1ns/10ps
module dacps_sample_path_tb_top;
	reg        sys_clk = 1'b0;
	reg        reset_n = 1'b0;
	reg        power_down = 1'b0;
	reg        clock_mode_strap_gnd = 1'b1;
	reg        clock_mode_strap_vdd = 1'b0;
	reg        go = 1'b0;
	wire [7:0] sample_data;
	wire       sample_valid;
	wire       sample_ready;
	wire [1:0] clock_rx_mode;
	wire       clock_rx_pecl_term;
	wire [7:0] primary_current_output;
	wire [7:0] complement_current_output;
	wire       output_current_on;
	wire       output_valid;
	wire       sample_update;
	integer    num_errors = 0;
	integer    checks_done = 0;
	integer    k;
	integer    t;
	always #4 sys_clk = ~sys_clk;
	dacps_sample_path u_dut (.sys_clk, .reset_n, .sample_data, .sample_valid,
		.sample_ready, .clock_mode_strap_gnd, .clock_mode_strap_vdd,
		.power_down, .clock_rx_mode, .clock_rx_pecl_term,
		.primary_current_output, .complement_current_output,
		.output_current_on, .output_valid, .sample_update);
	dacps_upstream_model u_src (.sys_clk, .reset_n, .go, .sample_ready,
		.sample_data, .sample_valid);
	task check(input [7:0] got, input [7:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task print_verdict;
		if (num_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task t_strap(input g, input v, input [1:0] m);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		clock_mode_strap_gnd <= g;
		clock_mode_strap_vdd <= v;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		check(clock_rx_mode, m);
		check(clock_rx_pecl_term, m == 2'h2);
	endtask
	// bounded wait, words must arrive in order
	task t_recv;
		k = 0;
		t = 0;
		while (k < 16 && t < 100) begin
			@(posedge sys_clk);
			#1;
			t = t + 1;
			if (sample_update === 1'b1) begin
				check(primary_current_output, k * 17);
				check(complement_current_output, 255 - k * 17);
				k = k + 1;
			end
		end
		check(k, 16);
	endtask
	task t_burst;
		@(posedge sys_clk);
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
	endtask
	task t_sleep;
		@(posedge sys_clk);
		power_down <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		check(output_current_on, 1'b0);
		check(primary_current_output, 8'h00);
		t_burst;
		repeat (30) @(posedge sys_clk);
		#1;
		check(sample_ready, 1'b0);
		@(posedge sys_clk);
		power_down <= 1'b0;
		t = 0;
		while (output_valid !== 1'b1 && t < 800) begin
			@(posedge sys_clk);
			#1;
			t = t + 1;
		end
		check(t >= 600 && t < 800, 1'b1);
		check(primary_current_output, 8'hff);
		t_recv;
	endtask
	initial begin
		t_strap(1'b0, 1'b0, 2'h2);
		t_strap(1'b0, 1'b1, 2'h1);
		t_strap(1'b1, 1'b1, 2'h0);
		t_strap(1'b1, 1'b0, 2'h0);
		t_burst;
		t_recv;
		repeat (5) @(posedge sys_clk);
		#1;
		check(primary_current_output, 8'hff);
		t_sleep;
		print_verdict;
	end
	initial begin
		#100000;
		num_errors = num_errors + 1;
		print_verdict;
	end
endmodule // dacps_sample_path_tb_top
